// ===== src/pio_pkg.sv
package pio_pkg;
	// ----------------------------------------
	// widths and port selection codes
	// ----------------------------------------
	localparam int PIO_WIDTH = 8;
	localparam int PIO_SEL_W = 2;
	localparam logic [1:0] PIO_SEL_ZERO = 2'h0;
	localparam logic [1:0] PIO_SEL_ONE = 2'h1;
	localparam logic [1:0] PIO_SEL_TWO = 2'h2;

	// ----------------------------------------
	// latch values after reset
	// ----------------------------------------
	localparam logic [7:0] PIO_P0_RESET = 8'hFF;
	localparam logic [7:0] PIO_P1_RESET = 8'hFF;
	localparam logic [7:0] PIO_P2_RESET = 8'hFF;
	localparam logic [7:0] PIO_ALL_ONES = 8'hFF;

	// ----------------------------------------
	// port one alternate pin positions
	// ----------------------------------------
	localparam int PIO_P1_T2_BIT = 0;
	localparam int PIO_P1_TIMER2_CAPTURE_TRIGGER_BIT = 1;
	localparam int PIO_P1_SS_BIT = 5;

	// ----------------------------------------
	// read-modify-write operations
	// ----------------------------------------
	localparam int PIO_OP_W = 3;
	localparam logic [2:0] PIO_OP_AND = 3'h0;
	localparam logic [2:0] PIO_OP_OR = 3'h1;
	localparam logic [2:0] PIO_OP_XOR = 3'h2;
	localparam logic [2:0] PIO_OP_INC = 3'h3;
	localparam logic [2:0] PIO_OP_DEC = 3'h4;
	localparam logic [2:0] PIO_OP_SETB = 3'h5;
	localparam logic [2:0] PIO_OP_CLRB = 3'h6;
	localparam logic [2:0] PIO_OP_CPL = 3'h7;

	// ----------------------------------------
	// pin input synchroniser depth
	// ----------------------------------------
	localparam int PIO_SYNC_STAGES = 2;
endpackage

// ===== src/pio_ports.sv
// Contract
// - port zero is eight open-drain bidirectional pins driven from its latch
// - port zero carries muxed low address and data during external accesses
// - each latch bit is a flip-flop loaded by the write strobe
// - read-latch returns the flip-flop, read-pin returns the pin level
// - any external access sets every port zero latch bit to one
// - external access drives port zero push-pull from the address/data bus
// - port zero latch one floats the pin, no high driver outside access
// - port zero latch zero drives the pin low
// - port one has no digital output, only digital or analogue input
// - port one latch resets to ones (analogue); zero selects digital input
// - port one pins 0, 1, 5 feed timer two and slave select
// - port two is bidirectional with pull-ups, driven from its latch
// - port two drives the upper address byte during external accesses
// - external access drives port two push-pull, latch left unchanged
// - port two latch one pulls the pin high and allows input
// - an enabled peripheral takes its pin away from port use
// - port two latch zero drives the pin low
// - read-modify-write reads the latch, modifies, writes back
`timescale 1ns/1ps
module pio_ports
	import pio_pkg::*;
#(
	parameter int WIDTH = pio_pkg::PIO_WIDTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	// core side
	input wire logic wr_strobe,
	input wire logic [pio_pkg::PIO_SEL_W-1:0] wr_sel,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_latch,
	input wire logic rd_pin,
	input wire logic [pio_pkg::PIO_SEL_W-1:0] rd_sel,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	input wire logic rmw_req,
	input wire logic [pio_pkg::PIO_SEL_W-1:0] rmw_sel,
	input wire logic [pio_pkg::PIO_OP_W-1:0] rmw_op,
	input wire logic [WIDTH-1:0] rmw_operand,
	input wire logic [2:0] rmw_bit,
	// external memory access
	input wire logic ext_access,
	input wire logic [WIDTH-1:0] ext_adl_out,
	input wire logic ext_adl_oe,
	input wire logic [WIDTH-1:0] ext_addr_hi,
	output logic [WIDTH-1:0] ext_adl_in,
	// port zero pins
	input wire logic [WIDTH-1:0] p0_in,
	output logic [WIDTH-1:0] p0_out,
	output logic [WIDTH-1:0] p0_oe,
	// port one pins
	input wire logic [WIDTH-1:0] p1_in,
	output logic [WIDTH-1:0] analog_input_en,
	output logic timer2_count_input,
	output logic timer2_capture_trigger,
	output logic spi_slave_select_n,
	input wire logic spi_enable,
	// port two pins
	input wire logic [WIDTH-1:0] p2_in,
	output logic [WIDTH-1:0] p2_out,
	output logic [WIDTH-1:0] p2_oe,
	output logic [WIDTH-1:0] p2_pullup_en,
	input wire logic [WIDTH-1:0] p2_periph_en,
	input wire logic [WIDTH-1:0] p2_periph_out
);
	import pio_pkg::*;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [WIDTH-1:0] rmw_apply(
		input logic [2:0] op,
		input logic [WIDTH-1:0] val,
		input logic [WIDTH-1:0] arg,
		input logic [2:0] pos
	);
		logic [WIDTH-1:0] mask;
		mask = {{(WIDTH-1){1'b0}}, 1'b1} << pos;
		case (op)
			PIO_OP_AND: rmw_apply = val & arg;
			PIO_OP_OR: rmw_apply = val | arg;
			PIO_OP_XOR: rmw_apply = val ^ arg;
			PIO_OP_INC: rmw_apply = WIDTH'(val + 1'b1);
			PIO_OP_DEC: rmw_apply = WIDTH'(val - 1'b1);
			PIO_OP_SETB: rmw_apply = val | mask;
			PIO_OP_CLRB: rmw_apply = val & ~mask;
			PIO_OP_CPL: rmw_apply = val ^ mask;
			default: rmw_apply = val;
		endcase
	endfunction

	function automatic logic port_hit(
		input logic [1:0] sel,
		input logic [1:0] code
	);
		port_hit = (sel == code);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [3*WIDTH-1:0] pins_s;
	logic [WIDTH-1:0] p0_s;
	logic [WIDTH-1:0] p1_s;
	logic [WIDTH-1:0] p2_s;

	pio_sync #(
		.WIDTH(3 * WIDTH)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.async_in({p2_in, p1_in, p0_in}),
		.sync_out(pins_s)
	);

	assign p0_s = pins_s[WIDTH-1:0];
	assign p1_s = pins_s[2*WIDTH-1:WIDTH];
	assign p2_s = pins_s[3*WIDTH-1:2*WIDTH];

	// ----------------------------------------
	// latches
	// ----------------------------------------
	logic [WIDTH-1:0] latch_q [3];
	logic [WIDTH-1:0] latch_d [3];
	logic [WIDTH-1:0] rmw_src;
	logic [WIDTH-1:0] rmw_res;

	// modify always starts from the latch, never the pin
	assign rmw_src = port_hit(rmw_sel, PIO_SEL_TWO) ? latch_q[2] :
		port_hit(rmw_sel, PIO_SEL_ONE) ? latch_q[1] : latch_q[0];
	assign rmw_res = rmw_apply(rmw_op, rmw_src, rmw_operand, rmw_bit);

	localparam logic [WIDTH-1:0] RST_VAL [3] = '{PIO_P0_RESET, PIO_P1_RESET, PIO_P2_RESET};

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_latch
			logic wr_hit;
			logic rmw_hit;
			logic ext_set;
			assign wr_hit = wr_strobe && port_hit(wr_sel, 2'(gp));
			assign rmw_hit = rmw_req && port_hit(rmw_sel, 2'(gp));
			// only port zero is overwritten by an external access
			assign ext_set = ext_access && (gp == 0);
			// external access beats a core write so the bus stays usable
			assign latch_d[gp] = ext_set ? PIO_ALL_ONES :
				wr_hit ? wr_data :
				rmw_hit ? rmw_res : latch_q[gp];

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					latch_q[gp] <= RST_VAL[gp];
				end else begin
					latch_q[gp] <= latch_d[gp];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// core read path
	// ----------------------------------------
	logic [WIDTH-1:0] p1_dig;
	logic [WIDTH-1:0] lat_sel;
	logic [WIDTH-1:0] pin_sel;
	logic [WIDTH-1:0] rd_data_d;
	logic [WIDTH-1:0] rd_data_q;
	logic rd_valid_q;

	// analogue pins have their digital buffer off and read as zero
	assign p1_dig = p1_s & ~latch_q[1];
	assign lat_sel = port_hit(rd_sel, PIO_SEL_TWO) ? latch_q[2] :
		port_hit(rd_sel, PIO_SEL_ONE) ? latch_q[1] : latch_q[0];
	assign pin_sel = port_hit(rd_sel, PIO_SEL_TWO) ? p2_s :
		port_hit(rd_sel, PIO_SEL_ONE) ? p1_dig : p0_s;
	// read-latch wins when both strobes come together
	assign rd_data_d = rd_latch ? lat_sel : pin_sel;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_latch || rd_pin;
			if (rd_latch || rd_pin) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;

	// ----------------------------------------
	// port zero drivers
	// ----------------------------------------
	// open drain: the high driver exists only during access
	assign p0_out = ext_access ? ext_adl_out : '0;
	assign p0_oe = ext_access ? {WIDTH{ext_adl_oe}} : ~latch_q[0];
	assign ext_adl_in = p0_s;

	// ----------------------------------------
	// port one inputs
	// ----------------------------------------
	// no output driver exists on port one at all
	assign analog_input_en = latch_q[1];
	assign timer2_count_input = p1_s[PIO_P1_T2_BIT];
	assign timer2_capture_trigger = p1_s[PIO_P1_TIMER2_CAPTURE_TRIGGER_BIT];
	// slave select idles high while the spi is off
	assign spi_slave_select_n = spi_enable ? p1_s[PIO_P1_SS_BIT] : 1'b1;

	// ----------------------------------------
	// port two drivers
	// ----------------------------------------
	logic [WIDTH-1:0] p2_gp_out;
	logic [WIDTH-1:0] p2_gp_oe;

	assign p2_gp_out = ext_access ? ext_addr_hi : '0;
	assign p2_gp_oe = ext_access ? PIO_ALL_ONES : ~latch_q[2];
	// peripheral output overrides the port bit
	assign p2_out = (p2_periph_en & p2_periph_out) | (~p2_periph_en & p2_gp_out);
	assign p2_oe = p2_periph_en | p2_gp_oe;
	assign p2_pullup_en = ext_access ? '0 : (latch_q[2] & ~p2_periph_en);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_ext_ones;
		@(posedge sys_clk) disable iff (!nrst)
		ext_access |=> latch_q[0] == PIO_ALL_ONES;
	endproperty
	a_ext_ones: assert property (p_ext_ones) else $error("port zero latch not all ones after access");

	property p_wr_latch;
		@(posedge sys_clk) disable iff (!nrst)
		(wr_strobe && wr_sel == PIO_SEL_TWO) |=> latch_q[2] == $past(wr_data);
	endproperty
	a_wr_latch: assert property (p_wr_latch) else $error("port two latch missed write");

	property p_rd_latch;
		@(posedge sys_clk) disable iff (!nrst)
		(rd_latch && rd_sel == PIO_SEL_ZERO) |=> rd_valid && rd_data == $past(latch_q[0]);
	endproperty
	a_rd_latch: assert property (p_rd_latch) else $error("read latch returned wrong value");

	property p_rd_pin;
		@(posedge sys_clk) disable iff (!nrst)
		(rd_pin && !rd_latch && rd_sel == PIO_SEL_TWO) ##1 1'b1 |-> rd_data == $past(p2_in, 3);
	endproperty
	a_rd_pin: assert property (p_rd_pin) else $error("read pin did not return pin level");

	property p_p0_gp;
		@(posedge sys_clk) disable iff (!nrst)
		!ext_access |-> p0_out == '0 && p0_oe == ~latch_q[0];
	endproperty
	a_p0_gp: assert property (p_p0_gp) else $error("port zero not open drain");

	property p_p0_ext;
		@(posedge sys_clk) disable iff (!nrst)
		ext_access |-> p0_out == ext_adl_out && p0_oe == {WIDTH{ext_adl_oe}};
	endproperty
	a_p0_ext: assert property (p_p0_ext) else $error("port zero not push-pull during access");

	property p_p2_ext;
		@(posedge sys_clk) disable iff (!nrst)
		(ext_access && p2_periph_en == '0) |-> p2_oe == PIO_ALL_ONES && p2_out == ext_addr_hi;
	endproperty
	a_p2_ext: assert property (p_p2_ext) else $error("port two missing address byte");

	property p_p2_keep;
		@(posedge sys_clk) disable iff (!nrst)
		(ext_access && !wr_strobe && !rmw_req) |=> $stable(latch_q[2]);
	endproperty
	a_p2_keep: assert property (p_p2_keep) else $error("port two latch changed by access");

	property p_p2_gp;
		@(posedge sys_clk) disable iff (!nrst)
		(!ext_access && p2_periph_en == '0) |-> p2_pullup_en == latch_q[2] && p2_oe == ~latch_q[2];
	endproperty
	a_p2_gp: assert property (p_p2_gp) else $error("port two pull-up or low drive wrong");

	property p_rmw_inc;
		@(posedge sys_clk) disable iff (!nrst)
		(rmw_req && !wr_strobe && !ext_access && rmw_sel == PIO_SEL_TWO && rmw_op == PIO_OP_INC)
			|=> latch_q[2] == WIDTH'($past(latch_q[2]) + 1'b1);
	endproperty
	a_rmw_inc: assert property (p_rmw_inc) else $error("increment did not use latch");

	property p_periph;
		@(posedge sys_clk) disable iff (!nrst)
		(p2_periph_en != '0) |-> (p2_oe & p2_periph_en) == p2_periph_en &&
			((p2_out ^ p2_periph_out) & p2_periph_en) == '0;
	endproperty
	a_periph: assert property (p_periph) else $error("peripheral did not own pin");

	property p_t2;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(p1_in[0]) ##2 1'b1 |-> timer2_count_input;
	endproperty
	a_t2: assert property (p_t2) else $error("timer two input not passed through");
endmodule // pio_ports

// ===== src/pio_sync.sv
`timescale 1ns/1ps
module pio_sync #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	// first stage feeds only the second
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // pio_sync

// ===== verif/pio_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// pins seen from the board side
// ----------------------------------------
module pio_pin_model (
	input wire logic sys_clk,
	input wire logic [7:0] p0_out,
	input wire logic [7:0] p0_oe,
	input wire logic [7:0] p2_out,
	input wire logic [7:0] p2_oe,
	input wire logic [7:0] p2_pullup_en,
	input wire logic [7:0] ext_en0,
	input wire logic [7:0] ext_val0,
	input wire logic [7:0] ext_en2,
	input wire logic [7:0] ext_val2,
	output logic [7:0] p0_in,
	output logic [7:0] p2_in
);
	logic [7:0] float_q;
	initial float_q = 8'h00;
	// released pin with no pull-up wanders, so a stale value never reads back
	always @(posedge sys_clk) float_q <= {float_q[6:0], ~float_q[7]};
	// board pull-ups on port zero, open-drain needs them
	assign p0_in = (p0_oe & p0_out) | (~p0_oe & ext_en0 & ext_val0) | (~p0_oe & ~ext_en0);
	assign p2_in = (p2_oe & p2_out) | (~p2_oe & ext_en2 & ext_val2) | (~p2_oe & ~ext_en2 & (p2_pullup_en | float_q));
endmodule // pio_pin_model

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import pio_pkg::*;
	logic sys_clk, nrst, wr_strobe, rd_latch, rd_pin, rd_valid, rmw_req, ext_access, ext_adl_oe;
	logic spi_enable, timer2_count_input, timer2_capture_trigger, spi_slave_select_n;
	logic [1:0] wr_sel, rd_sel, rmw_sel;
	logic [2:0] rmw_op, rmw_bit;
	logic [7:0] wr_data, rd_data, rmw_operand, ext_adl_out, ext_addr_hi, ext_adl_in, p0_in, p0_out, p0_oe;
	logic [7:0] p1_in, analog_input_en, p2_in, p2_out, p2_oe, p2_pullup_en, p2_periph_en, p2_periph_out;
	logic [7:0] ext_en0, ext_val0, ext_en2, ext_val2;
	int n_mismatch, n_tests;

	pio_ports dut_u (.sys_clk(sys_clk), .nrst(nrst), .wr_strobe(wr_strobe), .wr_sel(wr_sel), .wr_data(wr_data),
		.rd_latch(rd_latch), .rd_pin(rd_pin), .rd_sel(rd_sel), .rd_data(rd_data), .rd_valid(rd_valid),
		.rmw_req(rmw_req), .rmw_sel(rmw_sel), .rmw_op(rmw_op), .rmw_operand(rmw_operand), .rmw_bit(rmw_bit),
		.ext_access(ext_access), .ext_adl_out(ext_adl_out), .ext_adl_oe(ext_adl_oe), .ext_addr_hi(ext_addr_hi),
		.ext_adl_in(ext_adl_in), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in),
		.analog_input_en(analog_input_en), .timer2_count_input(timer2_count_input),
		.timer2_capture_trigger(timer2_capture_trigger), .spi_slave_select_n(spi_slave_select_n),
		.spi_enable(spi_enable), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pullup_en(p2_pullup_en),
		.p2_periph_en(p2_periph_en), .p2_periph_out(p2_periph_out));
	pio_pin_model pins_u (.sys_clk(sys_clk), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe),
		.p2_pullup_en(p2_pullup_en), .ext_en0(ext_en0), .ext_val0(ext_val0), .ext_en2(ext_en2),
		.ext_val2(ext_val2), .p0_in(p0_in), .p2_in(p2_in));

	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] sel, input logic [7:0] data);
		@(negedge sys_clk);
		wr_strobe = 1'b1;
		wr_sel = sel;
		wr_data = data;
		@(negedge sys_clk);
		wr_strobe = 1'b0;
	endtask
	task automatic rd(input logic pin, input logic [1:0] sel, input logic [7:0] exp);
		@(negedge sys_clk);
		rd_latch = ~pin;
		rd_pin = pin;
		rd_sel = sel;
		@(negedge sys_clk);
		rd_latch = 1'b0;
		rd_pin = 1'b0;
		chk({7'h00, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask
	// pins pass a two-flop synchroniser before a pin read sees them
	task automatic settle();
		repeat (3) @(negedge sys_clk);
	endtask
	function automatic logic [7:0] rmw_ref(input logic [7:0] v, input logic [2:0] op, input logic [7:0] a,
		input logic [2:0] b);
		case (op)
			3'h0: return v & a;
			3'h1: return v | a;
			3'h2: return v ^ a;
			3'h3: return v + 8'h01;
			3'h4: return v - 8'h01;
			3'h5: return v | (8'h01 << b);
			3'h6: return v & ~(8'h01 << b);
			default: return v ^ (8'h01 << b);
		endcase
	endfunction

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(analog_input_en, 8'hFF);
		chk(p0_oe, 8'h00);
		chk(p2_pullup_en, 8'hFF);
		rd(1'b0, 2'h0, 8'hFF);
		rd(1'b0, 2'h2, 8'hFF);
	endtask
	task automatic t_port0();
		wr(2'h0, 8'h5A);
		chk(p0_oe, 8'hA5);
		chk(p0_out, 8'h00);
		rd(1'b0, 2'h0, 8'h5A);
		ext_en0 = 8'h02;
		ext_val0 = 8'h00;
		settle();
		rd(1'b1, 2'h0, 8'h58);
		rd(1'b0, 2'h0, 8'h5A);
		ext_en0 = 8'h00;
	endtask
	task automatic t_port2();
		wr(2'h2, 8'h3C);
		chk(p2_oe, 8'hC3);
		chk(p2_pullup_en, 8'h3C);
		ext_en2 = 8'h04;
		ext_val2 = 8'h00;
		settle();
		rd(1'b1, 2'h2, 8'h38);
		wr(2'h3, 8'h00);
		chk(p2_oe, 8'hC3);
		chk(p0_oe, 8'hA5);
	endtask
	task automatic t_ext();
		@(negedge sys_clk);
		ext_access = 1'b1;
		ext_adl_out = 8'hA5;
		ext_adl_oe = 1'b1;
		ext_addr_hi = 8'h96;
		#1;
		chk(p0_out, 8'hA5);
		chk(p0_oe, 8'hFF);
		chk(p2_out, 8'h96);
		chk(p2_oe, 8'hFF);
		settle();
		chk(ext_adl_in, 8'hA5);
		@(negedge sys_clk);
		ext_access = 1'b0;
		ext_adl_oe = 1'b0;
		#1;
		chk(p0_oe, 8'h00);
		rd(1'b0, 2'h0, 8'hFF);
		rd(1'b0, 2'h2, 8'h3C);
	endtask
	// requests back to back, pin bit 2 held low while its latch bit is one
	task automatic t_rmw();
		logic [7:0] exp;
		exp = 8'h3C;
		for (int i = 0; i < 8; i++) begin
			@(negedge sys_clk);
			rmw_req = 1'b1;
			rmw_op = 3'(i);
			exp = rmw_ref(exp, 3'(i), rmw_operand, rmw_bit);
			@(posedge sys_clk);
			#1;
			chk(p2_pullup_en, exp);
		end
		@(negedge sys_clk);
		rmw_req = 1'b0;
		ext_en2 = 8'h00;
	endtask
	task automatic t_port1();
		wr(2'h1, 8'h0F);
		chk(analog_input_en, 8'h0F);
		p1_in = 8'hC1;
		spi_enable = 1'b1;
		settle();
		rd(1'b1, 2'h1, 8'hC0);
		chk({7'h00, timer2_count_input}, 8'h01);
		chk({7'h00, timer2_capture_trigger}, 8'h00);
		chk({7'h00, spi_slave_select_n}, 8'h00);
		spi_enable = 1'b0;
		settle();
		chk({7'h00, spi_slave_select_n}, 8'h01);
	endtask
	task automatic t_periph();
		@(negedge sys_clk);
		p2_periph_en = 8'h88;
		p2_periph_out = 8'h80;
		#1;
		chk(p2_out, 8'h80);
		chk(p2_oe, 8'hFF);
		chk(p2_pullup_en, 8'h00);
		@(negedge sys_clk);
		p2_periph_en = 8'h00;
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		#1000000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{sys_clk, nrst, wr_strobe, rd_latch, rd_pin, rmw_req, ext_access, ext_adl_oe, spi_enable} = '0;
		{wr_sel, rd_sel, rmw_sel, rmw_op} = '0;
		{wr_data, ext_adl_out, ext_addr_hi, p1_in, p2_periph_en, p2_periph_out} = '0;
		{ext_en0, ext_val0, ext_en2, ext_val2} = '0;
		rmw_sel = 2'h2;
		rmw_operand = 8'h0F;
		rmw_bit = 3'h3;
		n_mismatch = 0;
		n_tests = 0;
		repeat (12) @(negedge sys_clk);
		nrst = 1'b1;
		t_reset();
		t_port0();
		t_port2();
		t_ext();
		t_rmw();
		t_port1();
		t_periph();
		tally_and_finish();
	end
endmodule // tb_top
